/* File: logic/spd_link.sv */
// Slave shift engine clocked by the external serial clock
`timescale 1ns/1ps
module spd_link (
   input wire logic link_clk_i,
   input wire logic link_rst_i,
   input wire logic tgl_rst_i,
   input wire logic [7:0] tx_byte_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic [7:0] rx_byte_o,
   output logic done_tgl_o
);
   logic [2:0] cnt_ff, nxt_cnt;
   logic [6:0] sh_ff, nxt_sh;
   logic [7:0] rx_ff, nxt_rx;
   logic tgl_ff, nxt_tgl;
   logic out_ff, nxt_out;

   // Sample edge: shift in MSB first, hand over a byte after eight bits
   always_comb
   begin
      nxt_cnt = cnt_ff + 3'h1;
      nxt_sh = {sh_ff[5:0], sdi_i};
      nxt_rx = rx_ff;
      nxt_tgl = tgl_ff;
      if (cnt_ff == 3'h7)
      begin
         nxt_rx = {sh_ff, sdi_i};
         nxt_tgl = ~tgl_ff;
      end
      nxt_out = tx_byte_i[3'h7 - cnt_ff];
   end

   // Port reset clears the counter and any partial byte at once
   always_ff @(posedge link_clk_i or posedge link_rst_i)
   begin
      if (link_rst_i)
      begin
         cnt_ff <= 3'h0;
         sh_ff <= 7'h00;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
      end
   end

   // Finished byte survives select release until the system side has taken it
   always_ff @(posedge link_clk_i or posedge tgl_rst_i)
   begin
      if (tgl_rst_i)
      begin
         tgl_ff <= 1'b0;
         rx_ff <= 8'h00;
      end
      else
      begin
         tgl_ff <= nxt_tgl;
         rx_ff <= nxt_rx;
      end
   end

   always_ff @(negedge link_clk_i or posedge link_rst_i)
   begin
      if (link_rst_i)
         out_ff <= 1'b0;
      else
         out_ff <= nxt_out;
   end

   assign sdo_o = (cnt_ff == 3'h0) ? tx_byte_i[7] : out_ff;
   assign rx_byte_o = rx_ff;
   assign done_tgl_o = tgl_ff;
endmodule // spd_link

/* File: logic/spd_pkg.sv */
// Shared constants and carrier types for the serial port with memory engine
package spd_pkg;
   localparam logic [3:0] MODE_DIV4 = 4'h0;
   localparam logic [3:0] MODE_DIV16 = 4'h1;
   localparam logic [3:0] MODE_DIV64 = 4'h2;
   localparam logic [3:0] MODE_TBASE = 4'h3;
   localparam logic [3:0] MODE_SLV_SEL = 4'h4;
   localparam logic [3:0] MODE_SLV_FREE = 4'h5;
   localparam logic [3:0] MODE_DIVREG = 4'hA;
   localparam logic [9:0] HALF_DIV4 = 10'h002;
   localparam logic [9:0] HALF_DIV16 = 10'h008;
   localparam logic [9:0] HALF_DIV64 = 10'h020;
   localparam int MODE_LSB = 0;
   localparam int IDLE_LVL_BIT = 4;
   localparam int PORT_EN_BIT = 5;
   localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
   localparam logic [7:0] DUMMY_TX = 8'hFF;
   localparam logic [1:0] DUP_RX = 2'h0;
   localparam logic [1:0] DUP_TX = 2'h1;
   localparam logic [1:0] DUP_FULL = 2'h2;

   typedef struct packed {
      logic [7:0] ctrl_one;
      logic edge_sel;
      logic sdo_is_out;
      logic irq_en;
      logic [7:0] rate_div;
   } spd_cfg_t;

   typedef struct packed {
      logic [11:0] tx_ptr;
      logic [11:0] rx_ptr;
      logic [9:0] count;
      logic [1:0] duplex;
      logic tx_inc;
      logic rx_inc;
   } spd_eng_cfg_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [11:0] addr;
      logic [7:0] wdata;
   } spd_mem_req_t;

   localparam spd_cfg_t CFG_RST = '0;
   localparam spd_mem_req_t MEM_IDLE = '0;
endpackage

/* File: logic/spd_port.sv */
// Serial port one: master and slave shifting, select control and memory engine
`timescale 1ns/1ps
// What this block does
// - Select-controlled slave shifts and drives output only while select is low.
// - Select rising releases the output on the fifth system clock edge after it, via the synchroniser, even inside a byte.
// - Select high or port disable resets the port; bit counter goes to zero.
// - Output configured as input never drives, allowing one-wire receive-only use.
// - Master sleep freezes shifting; it resumes from the same point on wake.
// - Transfer completion wakes the processor only when interrupts are enabled.
// - Slave shift register runs on the external clock; flag after eight bits.
// - Device reset disables the port and aborts any transfer.
// - Modes map idle level and edge select: 0,0=01 0,1=00 1,0=11 1,1=10.
// - Bit rate comes from this port's own four-bit clock mode field.
// - Shared time base mode makes the rate follow the common timer tick.
// - Engine on: bytes come from and go to memory; off: plain port.
// - Engine holds receive pointer, transmit pointer, byte count; all modes, duplexes.
// - Full-duplex master with pins looped back copies memory to memory.
// - Engine runs in idle, stops in sleep; poll run bit before sleeping.
// - Slave in sleep still moves one byte and raises the flag.
// - Deep sleep stops everything; configuration must be loaded again after.
// - Control register one bit 4 selects the serial clock idle level.
// - Control register one bit 5 enables the port; clearing resets it.
// - MSB first; after eight bits byte goes to buffer, full and flag set.
module spd_port (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic SCK_I,
   input wire logic SLAVE_SELECT_N_I,
   input wire logic SERIAL_IN_I,
   input wire logic SLEEP_I,
   input wire logic DEEP_SLEEP_I,
   input wire logic TIME_BASE_TICK_I,
   input wire logic CFG_LOAD_I,
   input wire spd_pkg::spd_cfg_t CFG_I,
   input wire logic TX_WR_I,
   input wire logic [7:0] TX_DATA_I,
   input wire logic BUF_READ_I,
   input wire logic FLAG_CLR_I,
   input wire logic ENG_START_I,
   input wire logic ENG_STOP_I,
   input wire spd_pkg::spd_eng_cfg_t ENG_CFG_I,
   input wire logic [7:0] MEM_RDATA_I,
   output logic SCK_O,
   output logic SCK_OE_O,
   output logic SDO_O,
   output logic SDO_OE_O,
   output logic [7:0] BUF_DATA_O,
   output logic BUF_FULL_O,
   output logic XFER_FLAG_O,
   output logic WAKE_O,
   output logic BUSY_O,
   output logic ENG_RUN_O,
   output spd_pkg::spd_mem_req_t MEM_O
);
   typedef enum logic {M_IDLE, M_SHIFT} spd_mst_t;
   typedef enum logic [2:0] {E_IDLE, E_FETCH, E_WAIT, E_LOAD, E_XFER, E_STORE} spd_eng_t;

   function automatic logic [9:0] half_len(input logic [3:0] mode, input logic [7:0] div);
      logic [9:0] t;
      t = 10'({2'h0, div}) + 10'h001;
      case (mode)
         spd_pkg::MODE_DIV16: half_len = spd_pkg::HALF_DIV16;
         spd_pkg::MODE_DIV64: half_len = spd_pkg::HALF_DIV64;
         spd_pkg::MODE_DIVREG: half_len = {t[8:0], 1'b0};
         default: half_len = spd_pkg::HALF_DIV4;
      endcase
   endfunction

   function automatic logic slave_mode(input logic [3:0] mode);
      slave_mode = (mode == spd_pkg::MODE_SLV_SEL) || (mode == spd_pkg::MODE_SLV_FREE);
   endfunction

   spd_pkg::spd_cfg_t cfg_ff, nxt_cfg;
   logic [3:0] mode;
   logic enable, idle_lvl, is_slave, ss_ctrl, port_rst;
   logic ss_n_s, sdi_s, done_s, link_rst, link_clk;
   logic l_sdo, l_tgl;
   logic [7:0] l_rx;

   // Configuration is lost in deep sleep and must be loaded again
   always_comb
   begin
      nxt_cfg = cfg_ff;
      if (DEEP_SLEEP_I)
         nxt_cfg = spd_pkg::CFG_RST;
      else if (CFG_LOAD_I)
         nxt_cfg = CFG_I;
   end

   always_ff @(posedge CLK_I)
   begin
      if (SYS_RST_I)
         cfg_ff <= spd_pkg::CFG_RST;
      else
         cfg_ff <= nxt_cfg;
   end

   assign mode = cfg_ff.ctrl_one[spd_pkg::MODE_LSB +: 4];
   assign enable = cfg_ff.ctrl_one[spd_pkg::PORT_EN_BIT];
   assign idle_lvl = cfg_ff.ctrl_one[spd_pkg::IDLE_LVL_BIT];
   assign is_slave = slave_mode(mode);
   assign ss_ctrl = (mode == spd_pkg::MODE_SLV_SEL);
   assign port_rst = ~enable | (ss_ctrl & ss_n_s);

   // Slave link: sample edge follows idle level and edge select
   assign link_clk = SCK_I ^ idle_lvl ^ ~cfg_ff.edge_sel;
   assign link_rst = SYS_RST_I | ~enable | ~is_slave | (ss_ctrl & SLAVE_SELECT_N_I);

   spd_sync #(.RST_VAL(1'b1)) u_ss (
      .clk_i(CLK_I), .rst_i(SYS_RST_I), .d_i(SLAVE_SELECT_N_I), .q_o(ss_n_s));
   spd_sync #(.RST_VAL(1'b0)) u_sdi (
      .clk_i(CLK_I), .rst_i(SYS_RST_I), .d_i(SERIAL_IN_I), .q_o(sdi_s));
   spd_sync #(.RST_VAL(1'b0)) u_done (
      .clk_i(CLK_I), .rst_i(SYS_RST_I), .d_i(l_tgl), .q_o(done_s));

   logic [7:0] tx_hold_ff, nxt_tx_hold;

   spd_link u_link (
      .link_clk_i(link_clk), .link_rst_i(link_rst), .tgl_rst_i(SYS_RST_I),
      .tx_byte_i(tx_hold_ff), .sdi_i(SERIAL_IN_I), .sdo_o(l_sdo),
      .rx_byte_o(l_rx), .done_tgl_o(l_tgl));

   // Master shifter, engine and flag groups
   spd_mst_t mst_state_ff, nxt_mst;
   logic [4:0] edge_cnt_ff, nxt_edge, e1;
   logic [9:0] half_cnt_ff, nxt_half;
   logic [7:0] rx_sh_ff, nxt_rxsh, start_data;
   logic sck_ff, nxt_sck, msdo_ff, nxt_msdo, busy_ff, tick, mst_done, start;
   spd_eng_t eng_state_ff, nxt_eng;
   logic eng_kick, eng_load, eng_run_ff;
   logic byte_done, slv_done, done_seen_ff;

   assign tick = (mode == spd_pkg::MODE_TBASE) ? TIME_BASE_TICK_I
               : (half_cnt_ff == half_len(mode, cfg_ff.rate_div) - 10'h001);
   assign start_data = eng_kick ? tx_hold_ff : TX_DATA_I;
   assign start = (TX_WR_I & ~eng_run_ff & ~is_slave) | eng_kick;

   always_comb
   begin
      nxt_mst = mst_state_ff;
      nxt_edge = edge_cnt_ff;
      nxt_half = half_cnt_ff;
      nxt_sck = sck_ff;
      nxt_rxsh = rx_sh_ff;
      nxt_msdo = msdo_ff;
      nxt_tx_hold = tx_hold_ff;
      mst_done = 1'b0;
      e1 = edge_cnt_ff + 5'h01;
      if (eng_load)
         nxt_tx_hold = (eng_state_ff == E_WAIT) ? MEM_RDATA_I : spd_pkg::DUMMY_TX;
      else if (TX_WR_I && !eng_run_ff && (is_slave || mst_state_ff == M_IDLE))
         nxt_tx_hold = TX_DATA_I;
      if (port_rst || is_slave)
      begin
         nxt_mst = M_IDLE;
         nxt_edge = 5'h00;
         nxt_half = 10'h000;
         nxt_sck = idle_lvl;
         nxt_msdo = 1'b0;
      end
      else if (!SLEEP_I)
      begin
         unique case (mst_state_ff)
            M_IDLE:
            begin
               nxt_sck = idle_lvl;
               if (start)
               begin
                  nxt_mst = M_SHIFT;
                  nxt_edge = 5'h00;
                  nxt_half = 10'h000;
                  nxt_msdo = start_data[7];
               end
            end
            M_SHIFT:
            begin
               nxt_half = half_cnt_ff + 10'h001;
               if (tick)
               begin
                  nxt_half = 10'h000;
                  nxt_sck = ~sck_ff;
                  nxt_edge = e1;
                  // Sampling the looped-back pin gives memory copies
                  if (cfg_ff.edge_sel ? e1[0] : ~e1[0])
                     nxt_rxsh = {rx_sh_ff[6:0], sdi_s};
                  if (e1 == spd_pkg::EDGES_PER_BYTE)
                  begin
                     nxt_mst = M_IDLE;
                     mst_done = 1'b1;
                  end
                  else if (cfg_ff.edge_sel)
                     nxt_msdo = tx_hold_ff[3'h7 - e1[3:1]];
                  else
                     nxt_msdo = tx_hold_ff[3'h7 - 3'((e1 - 5'h01) >> 1)];
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (SYS_RST_I)
      begin
         mst_state_ff <= M_IDLE;
         edge_cnt_ff <= 5'h00;
         half_cnt_ff <= 10'h000;
         sck_ff <= 1'b0;
         rx_sh_ff <= 8'h00;
         msdo_ff <= 1'b0;
         tx_hold_ff <= 8'h00;
         busy_ff <= 1'b0;
      end
      else
      begin
         mst_state_ff <= nxt_mst;
         edge_cnt_ff <= nxt_edge;
         half_cnt_ff <= nxt_half;
         sck_ff <= nxt_sck;
         rx_sh_ff <= nxt_rxsh;
         msdo_ff <= nxt_msdo;
         tx_hold_ff <= nxt_tx_hold;
         busy_ff <= (nxt_mst == M_SHIFT);
      end
   end

   // Memory engine
   logic [11:0] txp_ff, nxt_txp, rxp_ff, nxt_rxp;
   logic [10:0] left_ff, nxt_left;
   logic [1:0] dup_ff, nxt_dup;
   logic tinc_ff, nxt_tinc, rinc_ff, nxt_rinc, stop_ff, nxt_stop, last;
   spd_pkg::spd_mem_req_t mem_ff, nxt_mem;

   assign eng_kick = (eng_state_ff == E_LOAD) & ~is_slave;
   assign eng_load = (eng_state_ff == E_WAIT) || (eng_state_ff == E_LOAD && dup_ff == spd_pkg::DUP_RX
                     && tx_hold_ff != spd_pkg::DUMMY_TX);
   assign last = (left_ff == 11'h001) | stop_ff;

   always_comb
   begin
      nxt_eng = eng_state_ff;
      nxt_txp = txp_ff;
      nxt_rxp = rxp_ff;
      nxt_left = left_ff;
      nxt_dup = dup_ff;
      nxt_tinc = tinc_ff;
      nxt_rinc = rinc_ff;
      nxt_stop = stop_ff | ENG_STOP_I;
      nxt_mem = spd_pkg::MEM_IDLE;
      if (port_rst || DEEP_SLEEP_I)
      begin
         nxt_eng = E_IDLE;
         nxt_stop = 1'b0;
      end
      else if (!SLEEP_I)
      begin
         unique case (eng_state_ff)
            E_IDLE:
            begin
               nxt_stop = 1'b0;
               if (ENG_START_I)
               begin
                  nxt_txp = ENG_CFG_I.tx_ptr;
                  nxt_rxp = ENG_CFG_I.rx_ptr;
                  nxt_left = 11'({1'b0, ENG_CFG_I.count}) + 11'h001;
                  nxt_dup = ENG_CFG_I.duplex;
                  nxt_tinc = ENG_CFG_I.tx_inc;
                  nxt_rinc = ENG_CFG_I.rx_inc;
                  nxt_eng = (ENG_CFG_I.duplex == spd_pkg::DUP_RX) ? E_LOAD : E_FETCH;
               end
            end
            E_FETCH:
            begin
               nxt_mem = '{req: 1'b1, we: 1'b0, addr: txp_ff, wdata: 8'h00};
               nxt_eng = E_WAIT;
            end
            E_WAIT: nxt_eng = E_LOAD;
            E_LOAD: nxt_eng = E_XFER;
            E_XFER:
            begin
               if (byte_done)
               begin
                  if (tinc_ff)
                     nxt_txp = txp_ff + 12'h001;
                  if (dup_ff != spd_pkg::DUP_TX)
                  begin
                     nxt_mem = '{req: 1'b1, we: 1'b1, addr: rxp_ff,
                                 wdata: is_slave ? l_rx : nxt_rxsh};
                     nxt_eng = E_STORE;
                  end
                  else
                  begin
                     nxt_left = left_ff - 11'h001;
                     nxt_eng = last ? E_IDLE : E_FETCH;
                  end
               end
            end
            E_STORE:
            begin
               if (rinc_ff)
                  nxt_rxp = rxp_ff + 12'h001;
               nxt_left = left_ff - 11'h001;
               if (last)
                  nxt_eng = E_IDLE;
               else
                  nxt_eng = (dup_ff == spd_pkg::DUP_RX) ? E_LOAD : E_FETCH;
            end
            default: nxt_eng = E_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (SYS_RST_I)
      begin
         eng_state_ff <= E_IDLE;
         txp_ff <= 12'h000;
         rxp_ff <= 12'h000;
         left_ff <= 11'h000;
         dup_ff <= 2'h0;
         tinc_ff <= 1'b0;
         rinc_ff <= 1'b0;
         stop_ff <= 1'b0;
         mem_ff <= spd_pkg::MEM_IDLE;
         eng_run_ff <= 1'b0;
      end
      else
      begin
         eng_state_ff <= nxt_eng;
         txp_ff <= nxt_txp;
         rxp_ff <= nxt_rxp;
         left_ff <= nxt_left;
         dup_ff <= nxt_dup;
         tinc_ff <= nxt_tinc;
         rinc_ff <= nxt_rinc;
         stop_ff <= nxt_stop;
         mem_ff <= nxt_mem;
         eng_run_ff <= (nxt_eng != E_IDLE);
      end
   end

   // Buffer, flags, wake and pin enables
   logic [7:0] buf_ff, nxt_buf;
   logic buf_full_ff, nxt_buf_full, flag_ff, nxt_flag, wake_ff, nxt_wake;
   logic sdo_oe_ff, nxt_sdo_oe, sck_oe_ff, nxt_sck_oe;

   assign slv_done = (done_s != done_seen_ff) & is_slave & enable;
   assign byte_done = mst_done | slv_done;

   always_comb
   begin
      nxt_buf = buf_ff;
      nxt_buf_full = buf_full_ff & ~BUF_READ_I;
      nxt_flag = flag_ff & ~FLAG_CLR_I;
      if (byte_done)
      begin
         nxt_buf = is_slave ? l_rx : nxt_rxsh;
         nxt_buf_full = 1'b1;
         nxt_flag = 1'b1;
      end
      nxt_wake = nxt_flag & cfg_ff.irq_en;
      nxt_sdo_oe = enable & cfg_ff.sdo_is_out & ~(ss_ctrl & ss_n_s);
      nxt_sck_oe = enable & ~is_slave;
   end

   always_ff @(posedge CLK_I)
   begin
      if (SYS_RST_I)
      begin
         buf_ff <= 8'h00;
         buf_full_ff <= 1'b0;
         flag_ff <= 1'b0;
         wake_ff <= 1'b0;
         sdo_oe_ff <= 1'b0;
         sck_oe_ff <= 1'b0;
         done_seen_ff <= 1'b0;
      end
      else
      begin
         buf_ff <= nxt_buf;
         buf_full_ff <= nxt_buf_full;
         flag_ff <= nxt_flag;
         wake_ff <= nxt_wake;
         sdo_oe_ff <= nxt_sdo_oe;
         sck_oe_ff <= nxt_sck_oe;
         done_seen_ff <= done_s;
      end
   end

   assign SCK_O = sck_ff;
   assign SCK_OE_O = sck_oe_ff;
   assign SDO_O = is_slave ? l_sdo : msdo_ff;
   assign SDO_OE_O = sdo_oe_ff;
   assign BUF_DATA_O = buf_ff;
   assign BUF_FULL_O = buf_full_ff;
   assign XFER_FLAG_O = flag_ff;
   assign WAKE_O = wake_ff;
   assign BUSY_O = busy_ff;
   assign ENG_RUN_O = eng_run_ff;
   assign MEM_O = mem_ff;

   chk_select_release: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      ss_ctrl && ss_n_s |=> !SDO_OE_O) else $error("output driven while select high");
   chk_rx_only_pin: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !cfg_ff.sdo_is_out |=> !SDO_OE_O) else $error("output driven while set as input");
   chk_port_reset_count: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      port_rst |=> edge_cnt_ff == 5'h00 && !BUSY_O && !ENG_RUN_O)
      else $error("port reset left counter or transfer running");
   chk_sleep_freeze: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      SLEEP_I && mst_state_ff == M_SHIFT && !port_rst |=> $stable(edge_cnt_ff) && $stable(SCK_O))
      else $error("master moved during sleep");
   chk_wake_gate: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !cfg_ff.irq_en |=> !WAKE_O) else $error("wake without interrupt enable");
   chk_wake_on_done: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      byte_done && cfg_ff.irq_en |=> WAKE_O && XFER_FLAG_O) else $error("no wake after byte");
   chk_buffer_load: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      byte_done |=> BUF_FULL_O && BUF_DATA_O == $past(nxt_buf)) else $error("buffer not loaded");
   chk_idle_level: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      mst_state_ff == M_IDLE && !SLEEP_I |=> SCK_O == $past(idle_lvl))
      else $error("clock not at idle level");
   chk_engine_sleep: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      SLEEP_I && !port_rst && !DEEP_SLEEP_I |=> $stable(eng_state_ff))
      else $error("engine moved during sleep");
endmodule // spd_port

/* File: logic/spd_sync.sv */
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
module spd_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);
   logic s1_ff, s2_ff, s3_ff, q_ff;
   logic nxt_q;

   always_comb
   begin
      nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         q_ff <= RST_VAL;
      end
      else
      begin
         s1_ff <= d_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff <= nxt_q;
      end
   end

   assign q_o = q_ff;
endmodule // spd_sync

/* File: test/spd_far.sv */
// Far-side serial device: clocks frames for slave tests, loops data back otherwise
`timescale 1ns/1ps
module spd_far (
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   output logic sck_o,
   output logic sel_n_o,
   output logic sdi_o
);
   logic loop_en = 1'b0;
   logic drv = 1'b0;
   logic pat = 1'b0;
   logic [7:0] sh = 8'h00;
   logic [7:0] got = 8'h00;
   initial
   begin
      sck_o = 1'b0;
      sel_n_o = 1'b1;
   end
   always #3.7 pat = ~pat;
   // A released data line shows a changing pattern, never the last value
   always_comb sdi_o = drv ? sh[7] : ((loop_en && sdo_oe_i) ? sdo_i : pat);
   // Clock n bits MSB first; clock idles low outside frames
   task automatic frame(input logic [7:0] b, input int n);
      sel_n_o = 1'b0;
      sh = b;
      drv = 1'b1;
      #40;
      repeat (n)
      begin
         #3 sck_o = 1'b1;
         got = {got[6:0], sdo_i};
         #3 sck_o = 1'b0;
         sh = sh << 1;
      end
      #4 sel_n_o = 1'b1;
      drv = 1'b0;
   endtask
endmodule // spd_far

/* File: test/tb_spd_port.sv */
// Self-checking bench for serial port one
`timescale 1ns/1ps
module tb_spd_port;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sleep = 1'b0;
   logic deep = 1'b0;
   logic tick = 1'b0;
   logic [2:0] tc = 3'h0;
   logic load = 1'b0;
   spd_pkg::spd_cfg_t cfg = spd_pkg::CFG_RST;
   logic tx_wr = 1'b0;
   logic [7:0] tx_d = 8'h00;
   logic clr = 1'b0;
   logic eng_go = 1'b0;
   spd_pkg::spd_eng_cfg_t ecfg = '0;
   logic [7:0] mem_rd = 8'h00;
   logic sck_o, sck_oe, sdo, sdo_oe, full, flag, wake, busy, run, sc, sck, sel_n, sdi;
   logic [7:0] buf_d;
   spd_pkg::spd_mem_req_t mem;
   int bad_count = 0;
   int n_checks = 0;
   logic [11:0] wr_a [$];
   logic [7:0] wr_d [$];
   // Rows: irq, edge select, idle level, clock mode, byte
   logic [14:0] rows [7] = '{{3'h6, 4'h1, 8'hA5}, {3'h0, 4'h1, 8'h5A}, {3'h3, 4'h1, 8'h81},
      {3'h5, 4'h1, 8'h7E}, {3'h6, 4'h2, 8'h01}, {3'h2, 4'hA, 8'hFE}, {3'h4, 4'h3, 8'h3C}};
   spd_port DUT (.CLK_I(clk), .SYS_RST_I(rst), .SCK_I(sck), .SLAVE_SELECT_N_I(sel_n),
      .SERIAL_IN_I(sdi), .SLEEP_I(sleep), .DEEP_SLEEP_I(deep), .TIME_BASE_TICK_I(tick),
      .CFG_LOAD_I(load), .CFG_I(cfg), .TX_WR_I(tx_wr), .TX_DATA_I(tx_d), .BUF_READ_I(clr),
      .FLAG_CLR_I(clr), .ENG_START_I(eng_go), .ENG_STOP_I(1'b0), .ENG_CFG_I(ecfg),
      .MEM_RDATA_I(mem_rd), .SCK_O(sck_o), .SCK_OE_O(sck_oe), .SDO_O(sdo), .SDO_OE_O(sdo_oe),
      .BUF_DATA_O(buf_d), .BUF_FULL_O(full), .XFER_FLAG_O(flag), .WAKE_O(wake),
      .BUSY_O(busy), .ENG_RUN_O(run), .MEM_O(mem));
   spd_far u_far (.sdo_i(sdo), .sdo_oe_i(sdo_oe), .sck_o(sck), .sel_n_o(sel_n), .sdi_o(sdi));
   initial forever #2.5 clk = ~clk;
   always @(negedge clk)
   begin
      tc <= tc + 3'h1;
      tick <= (tc == 3'h7);
   end
   // Memory answers inside the request cycle and logs writes
   always @(negedge clk)
   begin
      mem_rd <= mem.addr[7:0] ^ 8'h3C;
      if (mem.req && mem.we)
      begin
         wr_a.push_back(mem.addr);
         wr_d.push_back(mem.wdata);
      end
   end
   task automatic close_out;
      if (bad_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Load disabled first, then enabled, then clear the flags
   task automatic setup(input logic [7:0] c, input logic e, input logic oe, input logic irq);
      @(negedge clk);
      cfg = '{8'h00, e, oe, irq, 8'h03};
      load = 1'b1;
      @(negedge clk);
      cfg.ctrl_one = c;
      @(negedge clk);
      load = 1'b0;
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      cyc(3);
   endtask
   task automatic wr(input logic [7:0] d);
      @(negedge clk);
      tx_d = d;
      tx_wr = 1'b1;
      @(negedge clk);
      tx_wr = 1'b0;
   endtask
   task automatic wait_free(input int lim);
      int k;
      k = 0;
      while ((busy !== 1'b0 || run !== 1'b0) && k < lim)
      begin
         @(negedge clk);
         k++;
      end
      chk("done", 12'(k == lim), 12'h0);
   endtask
   initial
   begin
      #300000;
      bad_count++;
      close_out();
   end
   initial
   begin
      cyc(10);
      rst = 1'b0;
      cyc(1);
      chk("rst oe", {sck_oe, sdo_oe, flag, busy}, 12'h0);
      u_far.loop_en = 1'b1;
      foreach (rows[i])
      begin
         setup({3'h1, rows[i][12], rows[i][11:8]}, rows[i][13], 1'b1, rows[i][14]);
         chk("sck idle", sck_o, rows[i][12]);
         wr(rows[i][7:0]);
         cyc(40);
         sleep = 1'b1;
         cyc(2);
         sc = sck_o;
         cyc(30);
         chk("sleep hold", {busy, sck_o}, {1'b1, sc});
         sleep = 1'b0;
         wait_free(2000);
         cyc(8);
         chk("rx byte", buf_d, rows[i][7:0]);
         chk("flags", {full, flag, wake}, {2'h3, rows[i][14]});
      end
      u_far.loop_en = 1'b0;
      setup(8'h24, 1'b1, 1'b1, 1'b1);
      wr(8'h3C);
      sleep = 1'b1;
      fork
         u_far.frame(8'hC3, 8);
         begin
            cyc(6);
            chk("oe sel", sdo_oe, 1'b1);
         end
      join
      cyc(10);
      sleep = 1'b0;
      chk("slave rx", buf_d, 8'hC3);
      chk("slave tx", u_far.got, 8'h3C);
      chk("slave flag", {flag, wake}, 2'h3);
      u_far.frame(8'hF0, 3);
      cyc(6);
      chk("oe drop", sdo_oe, 1'b0);
      u_far.frame(8'h69, 8);
      cyc(10);
      chk("after abort", buf_d, 8'h69);
      setup(8'h24, 1'b1, 1'b0, 1'b0);
      fork
         u_far.frame(8'h11, 8);
         begin
            cyc(6);
            chk("oe input", sdo_oe, 1'b0);
         end
      join
      setup(8'h21, 1'b1, 1'b1, 1'b0);
      u_far.loop_en = 1'b1;
      ecfg = '{12'h120, 12'h340, 10'h001, spd_pkg::DUP_FULL, 1'b1, 1'b1};
      @(negedge clk);
      eng_go = 1'b1;
      @(negedge clk);
      eng_go = 1'b0;
      cyc(2);
      chk("run", run, 1'b1);
      wait_free(3000);
      chk("writes", 12'(wr_a.size()), 12'h2);
      foreach (wr_a[i])
      begin
         chk("wr addr", wr_a[i], 12'(12'h340 + i));
         chk("wr data", wr_d[i], 8'(8'h20 + i) ^ 8'h3C);
      end
      deep = 1'b1;
      cyc(2);
      deep = 1'b0;
      cyc(3);
      chk("deep oe", sck_oe, 1'b0);
      setup(8'h21, 1'b1, 1'b1, 1'b0);
      wr(8'h55);
      cyc(20);
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      cyc(2);
      chk("abort", {busy, sck_oe, flag}, 12'h0);
      close_out();
   end
endmodule // tb_spd_port
